// file: rtl/cbs_bus_seq.sv
`timescale 1ns/10ps
module cbs_bus_seq
  import cbs_pkg::*;
(
  input  wire logic        ref_clk,          // crystal clock
  input  wire logic        rst,              // reset, already held long enough
  // cpu core side
  input  wire logic        cpu_req,          // start a machine cycle
  input  wire logic [2:0]  cpu_op,           // cbs_op_e
  input  wire logic [18:0] cpu_addr,         // translated memory address
  input  wire logic [15:0] cpu_io_addr,      // untranslated io address
  input  wire logic [7:0]  cpu_wdata,
  output logic             cpu_ready,        // accepts a request
  output logic             cpu_done,         // cycle completed pulse
  output logic      [7:0]  cpu_rdata,
  output logic             restart,          // high for as long as reset is held: resume at restart_addr
  output logic      [18:0] restart_addr,
  output logic             refresh_hold,     // refresh must not run now
  // pins
  output logic             sys_clk,
  output logic      [18:0] addr_out,
  output logic             addr_oe,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             memory_enable_n,
  output logic             io_enable_n,
  output logic             read_n,
  output logic             write_n,
  output logic             ctrl_oe,
  output logic             opcode_fetch_strobe_n,
  input  wire logic        wait_n,
  input  wire logic        bus_request_n,
  output logic             bus_grant_n
);

  typedef enum logic [2:0] {
    CBS_IDLE,
    CBS_T1,
    CBS_T2,
    CBS_TW,
    CBS_T3,
    CBS_TI,
    CBS_TX
  } cbs_state_e;

  cbs_state_e  state;
  cbs_op_e     op;
  logic        second_half;
  logic [18:0] addr_q;
  logic [7:0]  wdata_q;
  logic [2:0]  wait_cnt;
  logic [2:0]  prog_waits;
  logic        reg_wr;
  logic [7:0]  reg_value;
  logic        wait_lo;
  logic        breq_lo;
  logic [2:0]  wait_sync;
  logic [2:0]  breq_sync;
  logic        need_wait;
  logic        data_drive;

  // decode helpers
  function automatic logic op_is_io(input cbs_op_e o);
    op_is_io = (o == CBS_OP_IO_RD) || (o == CBS_OP_IO_WR);
  endfunction : op_is_io

  function automatic logic op_is_write(input cbs_op_e o);
    op_is_write = (o == CBS_OP_MEM_WR) || (o == CBS_OP_IO_WR);
  endfunction : op_is_write

  function automatic logic op_is_bus(input cbs_op_e o);
    op_is_bus = (o != CBS_OP_INTERNAL);
  endfunction : op_is_bus

  // states in which the combined wait decides the next state
  function automatic logic in_wait_window(input cbs_state_e s);
    in_wait_window = (s == CBS_T2) || (s == CBS_TW);
  endfunction : in_wait_window

  // io address of the wait control register
  function automatic logic at_wait_reg(input logic [18:0] a);
    at_wait_reg = (a[15:0] == WAIT_CTRL_ADDR);
  endfunction : at_wait_reg

  // address put out for a cycle: io addresses bypass translation
  function automatic logic [18:0] cycle_addr(input cbs_op_e o, input logic [18:0] mem_a, input logic [15:0] io_a);
    if (op_is_io(o)) begin
      cycle_addr = {3'h0, io_a};
    end else begin
      cycle_addr = mem_a;
    end
  endfunction : cycle_addr

  ////////////////////////////////////////////////////////////////////////////
  // crystal divider and wait register

  cbs_clk_div u_clk_div (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .sys_clk     (sys_clk),
    .second_half (second_half)
  );

  cbs_wait_ctrl u_wait_ctrl (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .reg_wr     (reg_wr),
    .reg_wdata  (wdata_q),
    .reg_value  (reg_value),
    .is_io      (op_is_io(op)),
    .is_int_io  (addr_q[15:0] <= INT_IO_LAST),
    .prog_waits (prog_waits)
  );

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, a change counts once stages two and three agree

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_sync <= 3'h7;
      breq_sync <= 3'h7;
    end else begin
      wait_sync <= {wait_sync[1:0], wait_n};
      breq_sync <= {breq_sync[1:0], bus_request_n};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_lo <= 1'b0;
      breq_lo <= 1'b0;
    end else begin
      if (wait_sync[1] == wait_sync[2]) begin
        wait_lo <= ~wait_sync[2];
      end
      if (breq_sync[1] == breq_sync[2]) begin
        breq_lo <= ~breq_sync[2];
      end
    end
  end

  // combined wait: external low or programmed count not yet spent
  assign need_wait = wait_lo || (wait_cnt < prog_waits);

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle sequencer; states advance at the end of the second half

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= CBS_IDLE;
    end else if (second_half) begin
      unique case (state)
        CBS_IDLE, CBS_T3, CBS_TI: begin
          if (breq_lo) begin
            state <= CBS_TX;
          end else if (cpu_req && op_is_bus(cbs_op_e'(cpu_op))) begin
            state <= CBS_T1;
          end else if (cpu_req) begin
            state <= CBS_TI;
          end else begin
            state <= CBS_IDLE;
          end
        end
        CBS_T1: begin
          state <= CBS_T2;
        end
        CBS_T2, CBS_TW: begin
          state <= need_wait ? CBS_TW : CBS_T3;
        end
        CBS_TX: begin
          state <= breq_lo ? CBS_TX : CBS_IDLE;
        end
      endcase
    end
  end

  // capture the request at the start of each cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op      <= CBS_OP_INTERNAL;
      addr_q  <= RESTART_ADDR;
      wdata_q <= 8'h00;
    end else if (second_half && cpu_ready && cpu_req) begin
      op      <= cbs_op_e'(cpu_op);
      wdata_q <= cpu_wdata;
      addr_q  <= cycle_addr(cbs_op_e'(cpu_op), cpu_addr, cpu_io_addr);
    end
  end

  // programmed wait counter, counted in T2 and each wait state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_cnt <= 3'h0;
    end else if (second_half && state == CBS_T1) begin
      wait_cnt <= 3'h0;
    end else if (second_half && in_wait_window(state) && wait_cnt != 3'h7) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data capture: fetch at T3 rising edge, other reads at T3 falling edge

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_rdata <= 8'h00;
    end else if (op == CBS_OP_FETCH && second_half && in_wait_window(state) && !need_wait) begin
      cpu_rdata <= data_in;
    end else if (state == CBS_T3 && !second_half && op == CBS_OP_IO_RD && at_wait_reg(addr_q)) begin
      cpu_rdata <= reg_value;
    end else if (state == CBS_T3 && !second_half && (op == CBS_OP_MEM_RD || op == CBS_OP_IO_RD)) begin
      cpu_rdata <= data_in;
    end
  end

  // register write in T3 of an io write to its address
  assign reg_wr = second_half && state == CBS_T3 && op == CBS_OP_IO_WR && at_wait_reg(addr_q);

  // handshake with the core and restart vector
  assign cpu_ready    = second_half && (state == CBS_IDLE || state == CBS_T3 || state == CBS_TI) && !breq_lo;
  assign cpu_done     = second_half && (state == CBS_T3 || state == CBS_TI);
  assign restart      = rst;
  assign restart_addr = RESTART_ADDR;

  // refresh waits out wait states and bus release
  assign refresh_hold = state == CBS_TW || state == CBS_TX;

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  // address from the start of T1, held through waits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_out <= RESTART_ADDR;
    end else if (second_half && cpu_ready && cpu_req) begin
      addr_out <= cycle_addr(cbs_op_e'(cpu_op), cpu_addr, cpu_io_addr);
    end
  end

  // enables and read asserted in T1 second half, write from T2, fetch strobe through all of T1; held stable through wait states
  always_comb begin
    memory_enable_n       = 1'b1;
    io_enable_n           = 1'b1;
    read_n                = 1'b1;
    write_n               = 1'b1;
    opcode_fetch_strobe_n = 1'b1;
    if (state == CBS_T1 || state == CBS_T2 || state == CBS_TW || state == CBS_T3) begin
      opcode_fetch_strobe_n = (op != CBS_OP_FETCH);
      if (!(state == CBS_T1 && !second_half) && !(state == CBS_T3 && second_half && op_is_write(op))) begin
        memory_enable_n = op_is_io(op);
        io_enable_n     = !op_is_io(op);
        read_n          = op_is_write(op);
        write_n         = !(op_is_write(op) && state != CBS_T1);
      end
    end
  end

  // write data from end of T1 until T3 ends, after the strobes drop
  assign data_drive = op_is_write(op) && (in_wait_window(state) || state == CBS_T3);
  assign data_out   = wdata_q;
  assign data_oe    = data_drive;

  // float during release, grant only once floated
  assign addr_oe = state != CBS_TX;
  assign ctrl_oe = state != CBS_TX;

  // grant follows the floated bus by one crystal clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_grant_n <= 1'b1;
    end else begin
      bus_grant_n <= !(state == CBS_TX && breq_lo);
    end
  end

endmodule : cbs_bus_seq

// file: rtl/cbs_pkg.sv
package cbs_pkg;

  // register map
  localparam logic [15:0] WAIT_CTRL_ADDR   = 16'h0032;
  localparam int          MEM_WAIT_MSB     = 7;
  localparam int          MEM_WAIT_LSB     = 6;
  localparam int          IO_WAIT_MSB      = 5;
  localparam int          IO_WAIT_LSB      = 4;
  localparam logic [1:0]  MEM_WAIT_RESET   = 2'h3;
  localparam logic [1:0]  IO_WAIT_RESET    = 2'h3;
  localparam logic [7:0]  LOW_NIBBLE_RESET = 8'h00;
  // internal i/o window: these i/o addresses get no programmed wait states
  localparam logic [15:0] INT_IO_LAST      = 16'h003F;
  // restart address after reset
  localparam logic [18:0] RESTART_ADDR     = 19'h00000;
  // reset must be held this many system clocks
  localparam int          RESET_HOLD_CLKS  = 6;
  // system clock is crystal divided by this
  localparam int          CLK_DIVIDE       = 2;

  // cpu request kinds
  typedef enum logic [2:0] {
    CBS_OP_INTERNAL,
    CBS_OP_FETCH,
    CBS_OP_MEM_RD,
    CBS_OP_MEM_WR,
    CBS_OP_IO_RD,
    CBS_OP_IO_WR
  } cbs_op_e;

endpackage : cbs_pkg

// file: rtl/cbs_clk_div.sv
`timescale 1ns/10ps
// divides the crystal clock by two and marks the two halves of each system clock
module cbs_clk_div
  import cbs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  output logic      sys_clk,
  output logic      second_half
);

  logic [0:0] phase;

  // toggle on every rising crystal edge: phase 0 = first half (clock high), 1 = second half
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase <= 1'b0;
    end else if (phase == 1'(CLK_DIVIDE - 1)) begin
      phase <= 1'b0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  assign second_half = phase[0];
  assign sys_clk     = ~phase[0];

endmodule : cbs_clk_div

// file: rtl/cbs_wait_ctrl.sv
`timescale 1ns/10ps
// wait and transfer control register plus programmed wait count decode
module cbs_wait_ctrl
  import cbs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_value,
  input  wire logic       is_io,
  input  wire logic       is_int_io,
  output logic      [2:0] prog_waits
);

  logic [1:0] mem_wait;
  logic [1:0] io_wait;
  logic [3:0] low_bits;

  // fields are plain read/write, wait fields all ones and low nibble zero after reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_wait <= MEM_WAIT_RESET;
      io_wait  <= IO_WAIT_RESET;
      low_bits <= LOW_NIBBLE_RESET[3:0];
    end else if (reg_wr) begin
      mem_wait <= reg_wdata[MEM_WAIT_MSB:MEM_WAIT_LSB];
      io_wait  <= reg_wdata[IO_WAIT_MSB:IO_WAIT_LSB];
      low_bits <= reg_wdata[3:0];
    end
  end

  assign reg_value = {mem_wait, io_wait, low_bits};

  // memory: 0..3, external io: 1..4, internal io: none
  always_comb begin
    if (is_io && is_int_io) begin
      prog_waits = 3'h0;
    end else if (is_io) begin
      prog_waits = {1'b0, io_wait} + 3'h1;
    end else begin
      prog_waits = {1'b0, mem_wait};
    end
  end

endmodule : cbs_wait_ctrl

// file: test/cbs_bus_seq_asserts.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// port checks on the bus cycle sequencer
module cbs_bus_seq_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        sys_clk,
  input wire logic [18:0] addr_out,
  input wire logic        addr_oe,
  input wire logic        data_oe,
  input wire logic        memory_enable_n,
  input wire logic        io_enable_n,
  input wire logic        read_n,
  input wire logic        write_n,
  input wire logic        ctrl_oe,
  input wire logic        opcode_fetch_strobe_n,
  input wire logic        bus_request_n,
  input wire logic        bus_grant_n,
  input wire logic        refresh_hold,
  input wire logic [18:0] restart_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // clock, reset, strobe and bus grant relations
  clk_half_a: assert property (!$past(rst) |-> sys_clk != $past(sys_clk))
    else $error("system clock did not toggle");
  reset_idle_a: assert property ($fell(rst) |-> restart_addr == 19'h00000 && bus_grant_n && read_n && write_n)
    else $error("bad state leaving reset");
  io_upper_a: assert property (!io_enable_n |-> addr_out[18:16] == 3'h0 && memory_enable_n)
    else $error("io cycle upper address or enable wrong");
  fetch_mem_a: assert property (!opcode_fetch_strobe_n |-> io_enable_n && write_n)
    else $error("fetch strobe outside a memory read");
  write_data_a: assert property (!write_n |-> data_oe)
    else $error("write strobe without write data");
  data_after_a: assert property ($fell(data_oe) |-> $past(write_n))
    else $error("write data dropped before the strobe");
  wait_hold_a: assert property (refresh_hold && $past(refresh_hold) && addr_oe |->
    $stable(addr_out) && $stable(read_n) && $stable(memory_enable_n) && $stable(opcode_fetch_strobe_n))
    else $error("bus moved during a wait state");
  float_grant_a: assert property (!bus_grant_n |-> !addr_oe && !ctrl_oe && !data_oe && refresh_hold)
    else $error("bus driven or refresh allowed while granted");
  grant_order_a: assert property ($fell(bus_grant_n) |-> $past(!addr_oe) && $past(!ctrl_oe))
    else $error("grant before the bus floated");
  grant_end_a: assert property ($rose(bus_request_n) && !bus_grant_n |-> ##[1:8] bus_grant_n)
    else $error("grant held after request ended");
  // main scenarios
  cover property (!bus_grant_n);
  cover property (refresh_hold && addr_oe);
  cover property (!io_enable_n);
  cover property (!write_n);
endmodule : cbs_bus_seq_chk

bind cbs_bus_seq cbs_bus_seq_chk chk (
  .ref_clk, .rst, .sys_clk, .addr_out, .addr_oe, .data_oe, .memory_enable_n, .io_enable_n, .read_n,
  .write_n, .ctrl_oe, .opcode_fetch_strobe_n, .bus_request_n, .bus_grant_n, .refresh_hold, .restart_addr
);

// file: test/cbs_far_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// memory, io, wait source and alternate master
module cbs_far_model (
  input  wire logic        ref_clk,
  input  wire logic [18:0] addr_out,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe,
  input  wire logic        memory_enable_n,
  input  wire logic        io_enable_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        ctrl_oe,
  input  wire logic [4:0]  ext_len,
  input  wire logic        want_bus,
  output logic      [7:0]  data_in,
  output logic             wait_n,
  output logic             bus_request_n
);
  logic [7:0] mem [16];
  logic [7:0] last = 8'h00;
  logic [4:0] held = 5'h00;
  logic       sel;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'hA5 + 8'(i);
  end
  // store memory write data, count strobe time
  always @(posedge ref_clk) begin
    if (!write_n && !memory_enable_n && data_oe && ctrl_oe) mem[addr_out[3:0]] <= data_out;
    last <= data_in;
    held <= sel ? held + 5'h01 : 5'h00;
  end
  // read data only while selected, else a moving pattern
  assign sel           = !memory_enable_n || !io_enable_n;
  assign data_in       = (!read_n && ctrl_oe) ? mem[addr_out[3:0]] : ~last;
  assign wait_n        = !(sel && held < ext_len);
  assign bus_request_n = !want_bus;
endmodule : cbs_far_model

// file: test/cbs_bus_seq_test.sv
`timescale 1ns/10ps
module cbs_bus_seq_test
  import cbs_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cpu_req = 1'b0;
  logic [2:0]  cpu_op = 3'h0;
  logic [18:0] cpu_addr = 19'h00000;
  logic [15:0] cpu_io_addr = 16'h0000;
  logic [7:0]  cpu_wdata = 8'h00;
  logic [4:0]  ext_len = 5'h00;
  logic        want_bus = 1'b0;
  logic        cpu_ready, cpu_done, restart, refresh_hold, sys_clk, addr_oe, data_oe, ctrl_oe;
  logic        memory_enable_n, io_enable_n, read_n, write_n, opcode_fetch_strobe_n;
  logic        wait_n, bus_request_n, bus_grant_n, s_me, s_ioe, s_lir;
  logic [7:0]  cpu_rdata, data_in, data_out;
  logic [18:0] restart_addr, addr_out, s_addr;
  int          errors = 0;
  int          checks_done = 0;
  int          k;
  int          n;
  cbs_bus_seq DUT (
    .ref_clk, .rst, .cpu_req, .cpu_op, .cpu_addr, .cpu_io_addr, .cpu_wdata, .cpu_ready, .cpu_done,
    .cpu_rdata, .restart, .restart_addr, .refresh_hold, .sys_clk, .addr_out, .addr_oe, .data_in,
    .data_out, .data_oe, .memory_enable_n, .io_enable_n, .read_n, .write_n, .ctrl_oe,
    .opcode_fetch_strobe_n, .wait_n, .bus_request_n, .bus_grant_n
  );
  cbs_far_model far (
    .ref_clk, .addr_out, .data_out, .data_oe, .memory_enable_n, .io_enable_n, .read_n, .write_n,
    .ctrl_oe, .ext_len, .want_bus, .data_in, .wait_n, .bus_request_n
  );
  // crystal clock
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one machine cycle, k = falling edges from take to done
  task automatic cyc(input cbs_op_e op, input logic [18:0] a, input logic [7:0] wd);
    {cpu_op, cpu_addr, cpu_io_addr, cpu_wdata, cpu_req} = {op, a, a[15:0], wd, 1'b1};
    for (n = 0; cpu_ready !== 1'b1 && n < 200; n++) @(negedge ref_clk);
    if (n >= 200) errors++;
    @(negedge ref_clk);
    cpu_req = 1'b0;
    for (k = 1; cpu_done !== 1'b1 && k < 60; k++) @(negedge ref_clk);
    {s_addr, s_me, s_ioe, s_lir} = {addr_out, memory_enable_n, io_enable_n, opcode_fetch_strobe_n};
    @(negedge ref_clk);
  endtask : cyc
  // reset for six system clocks, then register defaults
  task automatic do_reset;
    rst = 1'b1;
    repeat (12) @(negedge ref_clk);
    check({18'h0, restart}, 19'h1);
    check(restart_addr, 19'h00000);
    rst = 1'b0;
    cyc(CBS_OP_IO_RD, 19'h00032, 8'h00);
    check(19'(cpu_rdata), 19'h000F0);
    check(19'(k), 19'd6);
    $display("reset test done");
  endtask : do_reset
  // memory waits per field value, fetch and write paths
  task automatic mem_test;
    for (int w = 0; w < 4; w++) begin
      cyc(CBS_OP_IO_WR, 19'h00032, {2'(w), 6'h00});
      cyc(CBS_OP_MEM_RD, 19'h40003 + 19'(w), 8'h00);
      check(19'(k), 19'(6 + 2 * w));
      check(19'(cpu_rdata), 19'(8'hA8 + 8'(w)));
      check({17'h0, s_me, s_lir}, 19'h1);
    end
    cyc(CBS_OP_MEM_WR, 19'h0000C, 8'h3C);
    cyc(CBS_OP_FETCH, 19'h0000C, 8'h00);
    check(19'(cpu_rdata), 19'h0003C);
    check({17'h0, s_me, s_lir}, 19'h0);
    check(s_addr, 19'h0000C);
    check(19'(k), 19'd12);
    $display("memory test done");
  endtask : mem_test
  // external io waits, address and enables
  task automatic io_test;
    for (int w = 0; w < 4; w++) begin
      cyc(CBS_OP_IO_WR, 19'h00032, {2'h0, 2'(w), 4'h0});
      cyc(CBS_OP_IO_RD, 19'h7A105, 8'h00);
      check(19'(k), 19'(8 + 2 * w));
      check(s_addr, 19'h0A105);
      check({17'h0, s_me, s_ioe}, 19'h2);
      check(19'(cpu_rdata), 19'h000AA);
    end
    cyc(CBS_OP_INTERNAL, 19'h00000, 8'h00);
    check(19'(k), 19'd2);
    $display("io test done");
  endtask : io_test
  // external wait longer than the programmed count
  task automatic wait_test;
    cyc(CBS_OP_IO_WR, 19'h00032, 8'h40);
    ext_len = 5'd12;
    cyc(CBS_OP_MEM_RD, 19'h00001, 8'h00);
    ext_len = 5'd0;
    check(19'(k > 8 && k < 24), 19'h1);
    check(19'(cpu_rdata), 19'h000A6);
    $display("wait test done");
  endtask : wait_test
  // request during a cycle, hold, give back
  task automatic bus_test;
    fork
      cyc(CBS_OP_MEM_RD, 19'h00002, 8'h00);
      begin
        repeat (3) @(negedge ref_clk);
        want_bus = 1'b1;
      end
    join
    check(19'(k), 19'd8);
    for (n = 0; bus_grant_n !== 1'b0 && n < 40; n++) @(negedge ref_clk);
    repeat (6) @(negedge ref_clk);
    check({14'h0, bus_grant_n, addr_oe, ctrl_oe, data_oe, refresh_hold}, 19'h1);
    want_bus = 1'b0;
    for (n = 0; bus_grant_n !== 1'b1 && n < 40; n++) @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
    check({16'h0, bus_grant_n, addr_oe, ctrl_oe}, 19'h7);
    cyc(CBS_OP_MEM_RD, 19'h00002, 8'h00);
    check(19'(cpu_rdata), 19'h000A7);
    $display("bus test done");
  endtask : bus_test
  // counts and verdict
  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // main sequence
  initial begin
    do_reset();
    mem_test();
    io_test();
    wait_test();
    bus_test();
    do_reset();
    results();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    results();
  end
endmodule : cbs_bus_seq_test
